// *** logic/static_memory_timing_pkg.sv ***
/*
  Package for the static memory timing block: register offsets, field
  positions, reset values, bus widths, request carriers and states.
  Assumes a single 250 MHz system clock and word-addressed memory.
*/
package static_memory_timing_pkg;

  // ==========================================================
  // Bus widths and set count
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int REG_AW = 4;
  localparam int NUM_SETS = 3;
  localparam int SET_W = 2;
  localparam int SYNC_STAGES = 3;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [REG_AW-1:0] TIMING0_OFFSET = 4'h0;
  localparam logic [REG_AW-1:0] TIMING1_OFFSET = 4'h4;
  localparam logic [REG_AW-1:0] TIMING2_OFFSET = 4'h8;
  localparam logic [REG_AW-1:0] STATUS_OFFSET = 4'hC;

  // ==========================================================
  // Timing register fields
  localparam int READY_WAIT_SELECT_POS = 26;
  localparam int BURST_PAGE_LENGTH_POS = 24;
  localparam int PAGE_ACCESS_SUPPORT_POS = 23;
  localparam int PAGE_READ_CYCLE_POS = 19;
  localparam int BUS_TURNAROUND_POS = 16;
  localparam int WRITE_PULSE_POS = 10;
  localparam int WRITE_HOLD_POS = 8;
  localparam int ADDRESS_SETUP_POS = 6;
  localparam int READ_CYCLE_POS = 0;
  localparam logic [31:0] TIMING_IMPL_MASK = 32'h07FF_FFFF;
  localparam logic [31:0] TIMING_RESET = 32'h041C_2D4B;

  // Page length code 0 means four words, each step doubles
  localparam int PAGE_BASE_SHIFT = 2;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic ready_wait_select;
    logic [1:0] burst_page_length;
    logic page_access_support;
    logic [3:0] page_read_cycle_time;
    logic [2:0] bus_turnaround_time;
    logic [5:0] write_pulse_width;
    logic [1:0] write_hold_time;
    logic [1:0] address_setup_time;
    logic [5:0] read_cycle_time;
  } timing_set_type;

  typedef struct packed {
    logic write;
    logic [SET_W-1:0] set;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mem_request_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_TURN = 3'b001,
    ST_SETUP = 3'b010,
    ST_WPULSE = 3'b011,
    ST_WHOLD = 3'b100,
    ST_READ = 3'b101
  } access_state_type;

endpackage

// *** logic/static_memory_timing_sets.sv ***
/*
  Static memory bus controller with three timing register sets. A user
  request port starts single read or write accesses on one of three chip
  selects; the selected set shapes every phase of the access except the bus turnaround, timed by the previous set.
  Assumes: one clock, synchronous active-high reset, register strobes never
  both high, memory ready pins asynchronous to the clock.
*/
`timescale 1ns/1ps

module static_memory_timing_sets
  import static_memory_timing_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  // Register port
  input wire logic [static_memory_timing_pkg::REG_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // User request port
  input wire logic req_valid,
  output logic req_ready,
  input wire static_memory_timing_pkg::mem_request_type req,
  output logic resp_valid,
  output logic [static_memory_timing_pkg::DATA_W-1:0] resp_rdata,
  // Memory pins
  output logic [static_memory_timing_pkg::ADDR_W-1:0] mem_addr,
  output logic [static_memory_timing_pkg::DATA_W-1:0] mem_data_out,
  output logic mem_data_oe,
  input wire logic [static_memory_timing_pkg::DATA_W-1:0] mem_data_in,
  output logic [static_memory_timing_pkg::NUM_SETS-1:0] mem_cs_n,
  output logic mem_oe_n,
  output logic mem_we_n,
  input wire logic [static_memory_timing_pkg::NUM_SETS-1:0] memory_ready_input
);
  import static_memory_timing_pkg::*;

  // ==========================================================
  // Helpers
  function automatic timing_set_type unpack_set(input logic [31:0] word);
    timing_set_type s;
    s.ready_wait_select = word[READY_WAIT_SELECT_POS];
    s.burst_page_length = word[BURST_PAGE_LENGTH_POS +: 2];
    s.page_access_support = word[PAGE_ACCESS_SUPPORT_POS];
    s.page_read_cycle_time = word[PAGE_READ_CYCLE_POS +: 4];
    s.bus_turnaround_time = word[BUS_TURNAROUND_POS +: 3];
    s.write_pulse_width = word[WRITE_PULSE_POS +: 6];
    s.write_hold_time = word[WRITE_HOLD_POS +: 2];
    s.address_setup_time = word[ADDRESS_SETUP_POS +: 2];
    s.read_cycle_time = word[READ_CYCLE_POS +: 6];
    return s;
  endfunction

  function automatic logic [SET_W-1:0] set_index(input logic [REG_AW-1:0] a);
    logic [SET_W-1:0] idx;
    idx = a[SET_W+1:2];
    return idx;
  endfunction

  // Page number of a word address for a given page length code
  function automatic logic [ADDR_W-1:0] page_of(input logic [ADDR_W-1:0] a, input logic [1:0] code);
    logic [ADDR_W-1:0] p;
    p = a >> (PAGE_BASE_SHIFT + int'(code));
    return p;
  endfunction

  // ==========================================================
  // Timing register sets
  logic [31:0] timing_r [NUM_SETS];
  logic [31:0] timing_nxt [NUM_SETS];
  timing_set_type tset [NUM_SETS];
  logic timing_hit;

  assign timing_hit = reg_write && (reg_addr[1:0] == 2'b00) && (set_index(reg_addr) < SET_W'(NUM_SETS));

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SETS; gi++)
    begin : g_set
      always_comb
      begin
        timing_nxt[gi] = timing_r[gi];
        if (timing_hit && (set_index(reg_addr) == SET_W'(gi)))
        begin
          timing_nxt[gi] = reg_wdata & TIMING_IMPL_MASK;
        end
      end

      always_ff @(posedge clock)
      begin
        if (rst)
        begin
          timing_r[gi] <= TIMING_RESET;
        end
        else
        begin
          timing_r[gi] <= timing_nxt[gi];
        end
      end

      assign tset[gi] = unpack_set(timing_r[gi]);
    end
  endgenerate

  // ==========================================================
  // Ready pin synchronisers
  logic [SYNC_STAGES-1:0] rdy_sync_r [NUM_SETS];
  logic [NUM_SETS-1:0] rdy_level_r;
  logic [NUM_SETS-1:0] rdy_level_nxt;

  generate
    for (gi = 0; gi < NUM_SETS; gi++)
    begin : g_rdy
      always_comb
      begin
        rdy_level_nxt[gi] = rdy_level_r[gi];
        if (rdy_sync_r[gi][1] == rdy_sync_r[gi][2])
        begin
          rdy_level_nxt[gi] = rdy_sync_r[gi][2];
        end
      end

      always_ff @(posedge clock)
      begin
        if (rst)
        begin
          rdy_sync_r[gi] <= '0;
          rdy_level_r[gi] <= 1'b0;
        end
        else
        begin
          rdy_sync_r[gi] <= {rdy_sync_r[gi][SYNC_STAGES-2:0], memory_ready_input[gi]};
          rdy_level_r[gi] <= rdy_level_nxt[gi];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Access sequencer
  access_state_type state_r, state_nxt;
  mem_request_type cur_r, cur_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic have_prev_r, have_prev_nxt;
  logic prev_write_r, prev_write_nxt;
  logic [SET_W-1:0] prev_set_r, prev_set_nxt;
  logic page_valid_r, page_valid_nxt;
  logic [ADDR_W-1:0] page_addr_r, page_addr_nxt;
  logic resp_valid_r, resp_valid_nxt;
  logic [DATA_W-1:0] resp_rdata_r, resp_rdata_nxt;
  mem_request_type start_req;
  timing_set_type cs_set, start_set;
  logic need_turn, page_hit, count_done, ready_ok;
  access_state_type first_state;
  logic [5:0] first_cnt;

  assign req_ready = (state_r == ST_IDLE);
  assign start_req = (state_r == ST_IDLE) ? req : cur_r;
  assign start_set = tset[start_req.set];
  assign cs_set = tset[cur_r.set];
  assign count_done = (cnt_r == 6'h00);
  assign ready_ok = !cs_set.ready_wait_select || rdy_level_r[cur_r.set];

  // turnaround on chip select change, not write-to-write
  assign need_turn = have_prev_r && (start_req.set != prev_set_r) && !(prev_write_r && start_req.write)
    && (tset[prev_set_r].bus_turnaround_time != 3'h0);

  // page hit only on page devices
  assign page_hit = start_set.page_access_support && page_valid_r && (start_req.set == prev_set_r)
    && (page_of(start_req.addr, start_set.burst_page_length)
        == page_of(page_addr_r, start_set.burst_page_length));

  // First phase of an access once turnaround is over
  always_comb
  begin
    first_state = ST_READ;
    first_cnt = 6'h00;
    if (start_req.write)
    begin
      if (start_set.address_setup_time != 2'h0)
      begin
        first_state = ST_SETUP;
        first_cnt = 6'(start_set.address_setup_time - 2'h1);
      end
      else
      begin
        first_state = ST_WPULSE;
        first_cnt = start_set.write_pulse_width;
      end
    end
    else if (page_hit)
    begin
      // page read of field plus one
      first_cnt = 6'(start_set.page_read_cycle_time);
    end
    else
    begin
      first_cnt = start_set.read_cycle_time;
    end
  end

  always_comb
  begin
    state_nxt = state_r;
    cur_nxt = cur_r;
    cnt_nxt = count_done ? cnt_r : 6'(cnt_r - 6'h01);
    have_prev_nxt = have_prev_r;
    prev_write_nxt = prev_write_r;
    prev_set_nxt = prev_set_r;
    page_valid_nxt = page_valid_r;
    page_addr_nxt = page_addr_r;
    resp_valid_nxt = 1'b0;
    resp_rdata_nxt = resp_rdata_r;
    case (state_r)
      ST_IDLE:
      begin
        if (req_valid)
        begin
          cur_nxt = req;
          if (need_turn)
          begin
            state_nxt = ST_TURN;
            cnt_nxt = 6'(tset[prev_set_r].bus_turnaround_time - 3'h1);
          end
          else
          begin
            state_nxt = first_state;
            cnt_nxt = first_cnt;
          end
        end
      end
      ST_TURN:
      begin
        if (count_done)
        begin
          state_nxt = first_state;
          cnt_nxt = first_cnt;
        end
      end
      ST_SETUP:
      begin
        if (count_done)
        begin
          state_nxt = ST_WPULSE;
          cnt_nxt = cs_set.write_pulse_width;
        end
      end
      ST_WPULSE:
      begin
        if (count_done && ready_ok)
        begin
          if (cs_set.write_hold_time != 2'h0)
          begin
            state_nxt = ST_WHOLD;
            cnt_nxt = 6'(cs_set.write_hold_time - 2'h1);
          end
          else
          begin
            state_nxt = ST_IDLE;
            resp_valid_nxt = 1'b1;
          end
          have_prev_nxt = 1'b1;
          prev_write_nxt = 1'b1;
          prev_set_nxt = cur_r.set;
          page_valid_nxt = 1'b0;
        end
      end
      ST_WHOLD:
      begin
        if (count_done)
        begin
          state_nxt = ST_IDLE;
          resp_valid_nxt = 1'b1;
        end
      end
      ST_READ:
      begin
        if (count_done && ready_ok)
        begin
          state_nxt = ST_IDLE;
          resp_valid_nxt = 1'b1;
          resp_rdata_nxt = mem_data_in;
          have_prev_nxt = 1'b1;
          prev_write_nxt = 1'b0;
          prev_set_nxt = cur_r.set;
          page_valid_nxt = 1'b1;
          page_addr_nxt = cur_r.addr;
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
    // Reprogramming a set may change its page layout
    if (timing_hit)
    begin
      page_valid_nxt = 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      cur_r <= '0;
      cnt_r <= 6'h00;
      have_prev_r <= 1'b0;
      prev_write_r <= 1'b0;
      prev_set_r <= '0;
      page_valid_r <= 1'b0;
      page_addr_r <= '0;
      resp_valid_r <= 1'b0;
      resp_rdata_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      cur_r <= cur_nxt;
      cnt_r <= cnt_nxt;
      have_prev_r <= have_prev_nxt;
      prev_write_r <= prev_write_nxt;
      prev_set_r <= prev_set_nxt;
      page_valid_r <= page_valid_nxt;
      page_addr_r <= page_addr_nxt;
      resp_valid_r <= resp_valid_nxt;
      resp_rdata_r <= resp_rdata_nxt;
    end
  end

  assign resp_valid = resp_valid_r;
  assign resp_rdata = resp_rdata_r;

  // ==========================================================
  // Memory pin registers
  logic [ADDR_W-1:0] mem_addr_r, mem_addr_nxt;
  logic [DATA_W-1:0] mem_data_r, mem_data_nxt;
  logic mem_data_oe_r, mem_data_oe_nxt;
  logic [NUM_SETS-1:0] mem_cs_n_r, mem_cs_n_nxt;
  logic mem_oe_n_r, mem_oe_n_nxt;
  logic mem_we_n_r, mem_we_n_nxt;
  logic active_nxt;

  assign active_nxt = (state_nxt == ST_SETUP) || (state_nxt == ST_WPULSE) || (state_nxt == ST_WHOLD)
    || (state_nxt == ST_READ);

  always_comb
  begin
    mem_addr_nxt = mem_addr_r;
    mem_data_nxt = mem_data_r;
    mem_cs_n_nxt = '1;
    mem_data_oe_nxt = cur_nxt.write && active_nxt;
    mem_oe_n_nxt = !(state_nxt == ST_READ);
    mem_we_n_nxt = !(state_nxt == ST_WPULSE);
    if (active_nxt)
    begin
      mem_addr_nxt = cur_nxt.addr;
      mem_data_nxt = cur_nxt.wdata;
      mem_cs_n_nxt[cur_nxt.set] = 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      mem_addr_r <= '0;
      mem_data_r <= '0;
      mem_data_oe_r <= 1'b0;
      mem_cs_n_r <= '1;
      mem_oe_n_r <= 1'b1;
      mem_we_n_r <= 1'b1;
    end
    else
    begin
      mem_addr_r <= mem_addr_nxt;
      mem_data_r <= mem_data_nxt;
      mem_data_oe_r <= mem_data_oe_nxt;
      mem_cs_n_r <= mem_cs_n_nxt;
      mem_oe_n_r <= mem_oe_n_nxt;
      mem_we_n_r <= mem_we_n_nxt;
    end
  end

  assign mem_addr = mem_addr_r;
  assign mem_data_out = mem_data_r;
  assign mem_data_oe = mem_data_oe_r;
  assign mem_cs_n = mem_cs_n_r;
  assign mem_oe_n = mem_oe_n_r;
  assign mem_we_n = mem_we_n_r;

  // ==========================================================
  // Register read port
  logic [31:0] rdata_r, rdata_nxt;

  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    if (reg_read)
    begin
      case (reg_addr)
        TIMING0_OFFSET: rdata_nxt = timing_r[0];
        TIMING1_OFFSET: rdata_nxt = timing_r[1];
        TIMING2_OFFSET: rdata_nxt = timing_r[2];
        STATUS_OFFSET: rdata_nxt = {22'h0, rdy_level_r, page_valid_r, cur_r.set, state_r, (state_r != ST_IDLE)};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

endmodule // static_memory_timing_sets

// *** dv/static_memory_timing_props.sv ***
/*
  Checker for the static memory timing block, bound to its top module.
  Assumes it sees the top ports only and keeps its own copy of the three sets.
*/
`timescale 1ns/1ps
module static_memory_timing_props
  import static_memory_timing_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [static_memory_timing_pkg::REG_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic mem_data_oe,
  input wire logic [static_memory_timing_pkg::NUM_SETS-1:0] mem_cs_n,
  input wire logic mem_oe_n,
  input wire logic mem_we_n,
  input wire logic [static_memory_timing_pkg::NUM_SETS-1:0] memory_ready_input
);
  import static_memory_timing_pkg::*;
  // ==========================================================
  // Shadow sets and phase counters
  timing_set_type sh_r [NUM_SETS];
  timing_set_type ts;
  logic [SET_W-1:0] cur_set_r;
  logic [SET_W-1:0] cs_idx;
  logic last_wr_r;
  logic any_cs;
  logic [31:0] rd_exp_r;
  int we_cnt_r, oe_cnt_r, cs_cnt_r, gap_cnt_r;
  assign any_cs = (mem_cs_n != 3'h7);
  assign cs_idx = !mem_cs_n[0] ? 2'h0 : (!mem_cs_n[1] ? 2'h1 : 2'h2);
  assign ts = sh_r[cur_set_r];
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_SETS; i++)
        sh_r[i] <= TIMING_RESET[26:0];
      cur_set_r <= 2'h0;
      last_wr_r <= 1'b1;
      rd_exp_r <= 32'h0;
    end
    else
    begin
      if (reg_write && reg_addr inside {TIMING0_OFFSET, TIMING1_OFFSET, TIMING2_OFFSET})
        sh_r[reg_addr[3:2]] <= reg_wdata[26:0];
      rd_exp_r <= 32'h0;
      if (reg_read && reg_addr inside {TIMING0_OFFSET, TIMING1_OFFSET, TIMING2_OFFSET})
        rd_exp_r <= {5'h00, sh_r[reg_addr[3:2]]};
      if (any_cs)
        cur_set_r <= cs_idx;
      if (!mem_we_n)
        last_wr_r <= 1'b1;
      else if (!mem_oe_n)
        last_wr_r <= 1'b0;
    end
    we_cnt_r <= (!rst && !mem_we_n) ? we_cnt_r + 1 : 0;
    oe_cnt_r <= (!rst && !mem_oe_n) ? oe_cnt_r + 1 : 0;
    cs_cnt_r <= (!rst && any_cs) ? cs_cnt_r + 1 : 0;
    gap_cnt_r <= (rst || any_cs) ? 0 : gap_cnt_r + 1;
  end
  // ==========================================================
  // Assertions
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  a_one_select: assert property ($onehot0(~mem_cs_n)) else $error("more than one chip select low");
  a_set_readback: assert property ($past(reg_read) && $past(reg_addr) != STATUS_OFFSET |-> reg_rdata == rd_exp_r)
    else $error("timing set read back wrong");
  a_strobe_inside: assert property (!mem_we_n |-> any_cs && mem_data_oe && mem_oe_n)
    else $error("write strobe outside a driven write");
  a_write_pulse: assert property ($rose(mem_we_n) && !ts.ready_wait_select |-> we_cnt_r == ts.write_pulse_width + 1)
    else $error("write pulse length wrong");
  a_write_setup: assert property ($fell(mem_we_n) |-> cs_cnt_r == ts.address_setup_time)
    else $error("address setup length wrong");
  a_write_total: assert property ($fell(any_cs) && last_wr_r && !ts.ready_wait_select |->
    cs_cnt_r == ts.address_setup_time + ts.write_pulse_width + 1 + ts.write_hold_time)
    else $error("write hold length wrong");
  a_read_cycle: assert property ($rose(mem_oe_n) && !ts.ready_wait_select |-> oe_cnt_r == ts.read_cycle_time + 1 ||
    (ts.page_access_support && oe_cnt_r == ts.page_read_cycle_time + 1))
    else $error("read cycle length wrong");
  a_bus_turnaround: assert property ($rose(any_cs) && cs_idx != cur_set_r && !last_wr_r |->
    gap_cnt_r >= ts.bus_turnaround_time)
    else $error("turnaround too short");
  a_ready_stall: assert property ((!mem_oe_n && ts.ready_wait_select && !memory_ready_input[cur_set_r])[*6]
    |=> !mem_oe_n)
    else $error("read ended while not ready");
  c_page_hit: cover property ($rose(mem_oe_n) && ts.page_access_support && oe_cnt_r == ts.page_read_cycle_time + 1);
  c_turnaround: cover property ($rose(any_cs) && cs_idx != cur_set_r && gap_cnt_r >= 7);
  c_ready_wait: cover property ($rose(mem_oe_n) && ts.ready_wait_select && oe_cnt_r > 20);
endmodule // static_memory_timing_props

// *** dv/static_memory_model.sv ***
/*
  Behavioural static memory on the parallel bus, 256 words deep.
  Assumes the bench steers its ready pins through stall_ready.
*/
`timescale 1ns/1ps
module static_memory_model
  import static_memory_timing_pkg::*;
(
  input wire logic clock,
  input wire logic [static_memory_timing_pkg::ADDR_W-1:0] mem_addr,
  input wire logic [static_memory_timing_pkg::DATA_W-1:0] mem_data_out,
  input wire logic mem_data_oe,
  input wire logic [static_memory_timing_pkg::NUM_SETS-1:0] mem_cs_n,
  input wire logic mem_oe_n,
  input wire logic mem_we_n,
  input wire logic stall_ready,
  output logic [static_memory_timing_pkg::DATA_W-1:0] mem_data_in,
  output logic [static_memory_timing_pkg::NUM_SETS-1:0] memory_ready_input
);
  import static_memory_timing_pkg::*;
  logic [DATA_W-1:0] store_r [256];
  logic [DATA_W-1:0] last_r = 16'h0000;
  initial
  begin
    for (int i = 0; i < 256; i++)
      store_r[i] = DATA_W'(i) ^ 16'hC3C3;
  end
  always @(posedge clock)
  begin
    last_r <= mem_data_in;
    if (!mem_we_n && mem_data_oe && mem_cs_n != 3'h7)
      store_r[mem_addr[7:0]] <= mem_data_out;
  end
  // Unselected bus toggles instead of holding
  assign mem_data_in = (!mem_oe_n && mem_cs_n != 3'h7) ? store_r[mem_addr[7:0]] : ~last_r;
  assign memory_ready_input = stall_ready ? 3'h0 : 3'h7;
endmodule // static_memory_model

// *** dv/static_memory_timing_sets_tb.sv ***
/*
  Self-checking bench for the static memory timing block.
  Assumes the memory model on the far side and the bound checker.
*/
`timescale 1ns/1ps
module static_memory_timing_sets_tb;
  import static_memory_timing_pkg::*;
  typedef struct packed { logic [3:0] a; logic [31:0] d; logic [31:0] e; } reg_row_type;
  typedef struct packed { logic w; logic [1:0] s; logic [7:0] a; logic [15:0] d; int n; int t; } acc_row_type;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [REG_AW-1:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic req_valid = 1'b0;
  logic req_ready, resp_valid, mem_data_oe, mem_oe_n, mem_we_n;
  logic stall = 1'b0;
  mem_request_type req = '0;
  logic [DATA_W-1:0] resp_rdata, mem_data_out, mem_data_in, rd;
  logic [ADDR_W-1:0] mem_addr;
  logic [NUM_SETS-1:0] mem_cs_n, memory_ready_input;
  int fails = 0;
  int cmp_count = 0;
  int csn, pre, base_pre;
  reg_row_type reg_rows [5] = '{'{4'h0, 32'hFFFF_FFFF, 32'h07FF_FFFF}, '{4'h0, 32'h0000_0943, 32'h0000_0943},
    '{4'h4, 32'h008F_0085, 32'h008F_0085}, '{4'h8, 32'hF400_0641, 32'h0400_0641}, '{4'h1, 32'hFFFF_FFFF, 32'h0}};
  acc_row_type acc_rows [12] = '{'{1, 0, 8'h10, 16'hA5A5, 5, -1}, '{1, 0, 8'h11, 16'h5A5A, 5, 0},
    '{0, 0, 8'h10, 16'hA5A5, 4, 0}, '{0, 1, 8'h11, 16'h5A5A, 6, 0}, '{0, 1, 8'h10, 16'hA5A5, 2, 0},
    '{0, 1, 8'h14, 16'hC3D7, 6, 0}, '{1, 0, 8'h20, 16'h1234, 5, 7}, '{0, 1, 8'h20, 16'h1234, 6, 0},
    '{0, 2, 8'h11, 16'h5A5A, 2, 7}, '{1, 1, 8'h30, 16'hBEEF, 3, 0}, '{0, 1, 8'h30, 16'hBEEF, 6, 0},
    '{1, 2, 8'h40, 16'h0F0F, 5, 7}};
  always #2 clock = ~clock;
  static_memory_timing_sets u_dut (.clock, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .req_valid, .req_ready, .req, .resp_valid, .resp_rdata, .mem_addr, .mem_data_out, .mem_data_oe,
    .mem_data_in, .mem_cs_n, .mem_oe_n, .mem_we_n, .memory_ready_input);
  static_memory_model u_mem (.clock, .mem_addr, .mem_data_out, .mem_data_oe, .mem_cs_n, .mem_oe_n,
    .mem_we_n, .stall_ready(stall), .mem_data_in, .memory_ready_input);
  // ==========================================================
  // Tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    check("reg_rdata", reg_rdata, exp);
  endtask
  task automatic run_row(input acc_row_type r);
    @(posedge clock);
    req_valid <= 1'b1;
    req <= '{write: r.w, set: r.s, addr: {16'h0000, r.a}, wdata: r.d};
    csn = 0;
    pre = 0;
    @(posedge clock);
    req_valid <= 1'b0;
    for (int k = 0; k < 2000; k++)
    begin
      #1;
      if (mem_cs_n != 3'h7)
        csn++;
      else if (csn == 0)
        pre++;
      if (resp_valid === 1'b1)
        break;
      @(posedge clock);
    end
    rd = resp_rdata;
    check("resp_valid", resp_valid, 1'b1);
    check("req_ready", req_ready, 1'b1);
    if (r.n > 0)
      check("cs_low_cycles", csn, r.n);
    if (r.t >= 0)
      check("lead_cycles", pre, base_pre + r.t);
    if (!r.w)
      check("resp_rdata", rd, r.d);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 3; i++)
      reg_rd(4'(i * 4), TIMING_RESET);
    foreach (reg_rows[i])
    begin
      reg_wr(reg_rows[i].a, reg_rows[i].d);
      reg_rd(reg_rows[i].a, reg_rows[i].e);
    end
    reg_rd(4'h0, 32'h0000_0943);
    base_pre = 0;
    foreach (acc_rows[i])
    begin
      run_row(acc_rows[i]);
      if (i == 0)
        base_pre = pre;
    end
    // Longest page: 32 words
    reg_wr(4'h4, 32'h038F_0085);
    run_row('{0, 1, 8'h20, 16'h1234, 6, 0});
    run_row('{0, 1, 8'h3F, 16'hC3FC, 2, 0});
    run_row('{0, 1, 8'h40, 16'h0F0F, 6, 0});
    // Eight and sixteen word pages
    reg_wr(4'h4, 32'h018F_0085);
    run_row('{0, 1, 8'h40, 16'h0F0F, 6, 0});
    run_row('{0, 1, 8'h47, 16'hC384, 2, 0});
    reg_wr(4'h4, 32'h028F_0085);
    run_row('{0, 1, 8'h48, 16'hC38B, 6, 0});
    run_row('{0, 1, 8'h4F, 16'hC38C, 2, 0});
    // Ready pins low: ignored by set 0, waited on by set 2
    stall <= 1'b1;
    run_row('{0, 0, 8'h10, 16'hA5A5, 4, 7});
    fork
      begin
        repeat (20) @(posedge clock);
        stall <= 1'b0;
      end
    join_none
    run_row('{0, 2, 8'h11, 16'h5A5A, 0, 0});
    check("stall_stretch", csn > 20, 1'b1);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    #1;
    check("cs_after_reset", mem_cs_n, 3'h7);
    reg_rd(4'h0, TIMING_RESET);
    reg_rd(4'h8, TIMING_RESET);
    reg_rd(4'hC, 32'h0000_0380);
    results();
  end
  initial
  begin
    #200000;
    fails++;
    results();
  end
endmodule // static_memory_timing_sets_tb
bind static_memory_timing_sets static_memory_timing_props u_props (.clock, .rst, .reg_addr, .reg_wdata,
  .reg_write, .reg_read, .reg_rdata, .mem_data_oe, .mem_cs_n, .mem_oe_n, .mem_we_n, .memory_ready_input);
